//--- afe_ctrl_defines.svh
`ifndef AFE_CTRL_DEFINES_SVH
`define AFE_CTRL_DEFINES_SVH

// Register offsets on the internal register port
`define OFS_WINDOW_START 7'h09
`define OFS_WINDOW_LENGTH 7'h0a
`define OFS_PIN_DIRECTION 7'h0e
`define OFS_PIN_DATA 7'h0f
`define OFS_READY_CONTROL 7'h11
`define OFS_CHECK_CONTROL 7'h13
`define OFS_CHECK_VALUE 7'h1d

// Reset values
`define RST_WINDOW_START 7'h1a
`define RST_WINDOW_COUNT 3'h2
`define RST_READY_FIXED 3'h3
`define RST_CHECK_FIXED 1'h0
`define RST_CHECK_VALUE 8'h00

// Field positions
`define BIT_READY_ON_PIN6 7
`define BIT_AUTO_CLEAR_OFF 5
`define BIT_GAIN_SEL 3
`define BIT_CHECK_ENABLE 4
`define BIT_CHECK_FIXED 3
`define BIT_RELEASE_AFTER 2

// Check polynomial (x^8 + x^2 + x + 1)
`define CHECK_POLY 8'h07

`endif

//--- afe_ctrl_pkg.sv
package afe_ctrl_pkg;

  // One access on the register port
  typedef struct packed {
    logic [6:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_s;

  // Data-ready sequence
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_READY = 2'b01,
    ST_WAIT_CHECK = 2'b10
  } ready_state_e;

endpackage

//--- afe_spi_crc_gpio_control_regs.sv
`timescale 1ns/1ps
`include "afe_ctrl_defines.svh"

module afe_spi_crc_gpio_control_regs (
  input wire logic core_clk,
  input wire logic rst,
  input wire afe_ctrl_pkg::reg_req_s reg_req,
  output logic [7:0] reg_rdata,
  input wire logic sample_done,
  input wire logic result_low_read,
  input wire logic [7:0] link_byte,
  input wire logic link_byte_valid,
  input wire logic [6:0] pin_in,
  output logic [6:0] pin_out,
  output logic [6:0] pin_oe,
  output logic ready_n,
  output logic [6:0] window_start,
  output logic [3:0] window_byte_count,
  output logic gain_correction_sel,
  output logic check_enable
);
  import afe_ctrl_pkg::*;

  // Stored control fields
  logic ready_on_pin6_sel; // Pin six carries ready
  logic auto_clear_off; // Suppress clear on release
  logic ready_release_after_check; // Hold ready until check byte read
  logic [2:0] window_field; // Raw byte-count code
  logic [6:0] pin_dir_bit; // Per-pin direction
  logic [6:0] pin_data; // Driven levels for output pins
  logic [7:0] check_value; // Running check accumulator
  ready_state_e state; // Ready sequence state
  ready_state_e next_state;
  logic release_evt; // Ready going inactive this cycle
  logic check_read; // Host reads check value
  logic check_write; // Host writes check value

  assign check_read = reg_req.rd && (reg_req.addr == `OFS_CHECK_VALUE);
  assign check_write = reg_req.wr && (reg_req.addr == `OFS_CHECK_VALUE);

  // One step of the check over a byte, MSB first
  function automatic logic [7:0] check_step(input logic [7:0] acc, input logic [7:0] din);
    logic [7:0] c;
    c = acc ^ din;
    for (int i = 0; i < 8; i++) begin
      c = c[7] ? ((c << 1) ^ `CHECK_POLY) : (c << 1);
    end
    return c;
  endfunction

  // Control register writes; reserved bits are never stored
  always_ff @(posedge core_clk) begin
    if (rst) begin
      window_start <= `RST_WINDOW_START;
      window_field <= `RST_WINDOW_COUNT;
      ready_on_pin6_sel <= 1'b0;
      auto_clear_off <= 1'b0;
      gain_correction_sel <= 1'b0;
      check_enable <= 1'b0;
      ready_release_after_check <= 1'b0;
      pin_dir_bit <= 7'h00;
    end else if (reg_req.wr) begin
      case (reg_req.addr)
        `OFS_WINDOW_START: window_start <= reg_req.wdata[6:0];
        `OFS_WINDOW_LENGTH: window_field <= reg_req.wdata[2:0];
        `OFS_PIN_DIRECTION: pin_dir_bit <= reg_req.wdata[6:0];
        `OFS_READY_CONTROL: begin
          ready_on_pin6_sel <= reg_req.wdata[`BIT_READY_ON_PIN6];
          auto_clear_off <= reg_req.wdata[`BIT_AUTO_CLEAR_OFF];
          gain_correction_sel <= reg_req.wdata[`BIT_GAIN_SEL];
        end
        `OFS_CHECK_CONTROL: begin
          check_enable <= reg_req.wdata[`BIT_CHECK_ENABLE];
          ready_release_after_check <= reg_req.wdata[`BIT_RELEASE_AFTER];
        end
        default: ;
      endcase
    end
  end

  // Byte count is presented already incremented so consumers need no adder
  always_ff @(posedge core_clk) begin
    if (rst) begin
      // Reset count follows the reset code, so the two can never disagree
      window_byte_count <= {1'b0, `RST_WINDOW_COUNT} + 4'h1;
    end else begin
      window_byte_count <= {1'b0, window_field} + 4'h1;
    end
  end

  // Pin data: bits of input pins ignore writes
  always_ff @(posedge core_clk) begin
    if (rst) begin
      pin_data <= 7'h00;
    end else if (reg_req.wr && reg_req.addr == `OFS_PIN_DATA) begin
      pin_data <= (pin_data & ~pin_dir_bit) | (reg_req.wdata[6:0] & pin_dir_bit);
    end
  end

  // Ready sequence; a fresh sample wins over a release in the same cycle
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: ;
      ST_READY: begin
        if (result_low_read) begin
          next_state = ready_release_after_check ? ST_WAIT_CHECK : ST_IDLE;
        end
      end
      ST_WAIT_CHECK: begin
        if (check_read) begin
          next_state = ST_IDLE;
        end
      end
      default: next_state = ST_IDLE;
    endcase
    if (sample_done) begin
      next_state = ST_READY;
    end
  end

  assign release_evt = (state != ST_IDLE) && (next_state == ST_IDLE);

  always_ff @(posedge core_clk) begin
    if (rst) begin
      state <= ST_IDLE;
      ready_n <= 1'b1;
    end else begin
      state <= next_state;
      ready_n <= (next_state == ST_IDLE);
    end
  end

  // Check accumulator; a host write or an auto clear overrides a byte in flight
  always_ff @(posedge core_clk) begin
    if (rst) begin
      check_value <= `RST_CHECK_VALUE;
    end else if (check_write) begin
      check_value <= `RST_CHECK_VALUE;
    end else if (release_evt && !auto_clear_off) begin
      check_value <= `RST_CHECK_VALUE;
    end else if (check_enable && link_byte_valid) begin
      check_value <= check_step(check_value, link_byte);
    end
  end

  // Pin drivers; with ready_on_pin6_sel set, pin six follows ready whatever its direction bit says
  always_ff @(posedge core_clk) begin
    if (rst) begin
      pin_out <= 7'h00;
      pin_oe <= 7'h00;
    end else begin
      pin_out <= pin_data;
      pin_oe <= pin_dir_bit;
      if (ready_on_pin6_sel) begin
        pin_out[6] <= (next_state == ST_IDLE);
        pin_oe[6] <= 1'b1;
      end
    end
  end

  // Read data, registered; unmapped offsets read zero
  always_ff @(posedge core_clk) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_req.rd) begin
      case (reg_req.addr)
        `OFS_WINDOW_START: reg_rdata <= {1'b0, window_start};
        `OFS_WINDOW_LENGTH: reg_rdata <= {5'h00, window_field};
        `OFS_PIN_DIRECTION: reg_rdata <= {1'b0, pin_dir_bit};
        // Output pins return what is driven, input pins their level
        `OFS_PIN_DATA: reg_rdata <= {1'b0, (pin_out & pin_oe) | (pin_in & ~pin_oe)};
        // Low bits fixed, so a stray host write cannot disturb them
        `OFS_READY_CONTROL: reg_rdata <= {ready_on_pin6_sel, 1'b0, auto_clear_off, 1'b0,
                                          gain_correction_sel, `RST_READY_FIXED};
        `OFS_CHECK_CONTROL: reg_rdata <= {3'h0, check_enable, `RST_CHECK_FIXED,
                                          ready_release_after_check, 2'h0};
        `OFS_CHECK_VALUE: reg_rdata <= check_value;
        default: reg_rdata <= 8'h00;
      endcase
    end
  end

  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  // Ready already asserted for two cycles, so the first cycle of a sample's ready is not covered
  sequence s_ready_held;
    !ready_n ##1 !ready_n;
  endsequence

  chk_start_write: assert property (
    reg_req.wr && reg_req.addr == `OFS_WINDOW_START |=> window_start == $past(reg_req.wdata[6:0]))
    else $error("window start not stored");
  chk_byte_count: assert property (
    reg_req.wr && reg_req.addr == `OFS_WINDOW_LENGTH
      |-> ##2 window_byte_count == {1'b0, $past(reg_req.wdata[2:0], 2)} + 4'h1)
    else $error("window byte count wrong");
  chk_pin6_ready: assert property (
    ready_on_pin6_sel && $past(ready_on_pin6_sel) |-> pin_oe[6] && pin_out[6] == ready_n)
    else $error("pin six not carrying ready");
  chk_release_clear: assert property (
    release_evt && !auto_clear_off && !sample_done |=> check_value == `RST_CHECK_VALUE)
    else $error("check not cleared on release");
  chk_check_idle: assert property (
    !check_enable && !check_write && !release_evt |=> $stable(check_value))
    else $error("check moved while disabled");
  chk_release_after: assert property (
    s_ready_held ##0 (ready_release_after_check && result_low_read && !sample_done
      && !check_read) |=> !ready_n)
    else $error("ready released before check byte");
  chk_check_reset: assert property (
    check_write |=> check_value == `RST_CHECK_VALUE)
    else $error("check write did not reset");
  chk_check_read: assert property (
    check_read |=> reg_rdata == $past(check_value))
    else $error("check read returned wrong value");
  chk_input_ignore: assert property (
    reg_req.wr && reg_req.addr == `OFS_PIN_DATA |=> (pin_data & ~pin_dir_bit)
      == ($past(pin_data) & ~pin_dir_bit))
    else $error("input pin data changed on write");
  chk_fixed_bits: assert property (
    reg_req.rd && reg_req.addr == `OFS_READY_CONTROL |=> reg_rdata[2:0] == `RST_READY_FIXED)
    else $error("fixed ready bits read wrong");

endmodule

//--- afe_host_model.sv
`timescale 1ns/1ps
// Host side of the register port: one access at a time, strobe held to the take edge
module afe_host_model (
  input wire logic core_clk,
  output afe_ctrl_pkg::reg_req_s req
);
  import afe_ctrl_pkg::*;
  // Idle port from time zero so no access is seen during reset
  initial req = '0;
  // Write; fixed control bits are forced to their required values
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] v;
    v = d;
    if (a == 7'h11) v[2:0] = 3'h3;
    if (a == 7'h13) v[3] = 1'b0;
    @(posedge core_clk);
    req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge core_clk);
    req.wr <= 1'b0;
  endtask
  // Read strobe; the data is registered at the take edge itself
  task automatic rd(input logic [6:0] a);
    @(posedge core_clk);
    req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge core_clk);
    req.rd <= 1'b0;
  endtask
endmodule

//--- afe_spi_crc_gpio_control_regs_test.sv
`timescale 1ns/1ps
// Self-checking bench for the control register bank
module afe_spi_crc_gpio_control_regs_test;
  import afe_ctrl_pkg::*;
  logic core_clk = 0, rst = 1, sample_done = 0, result_low_read = 0, link_byte_valid = 0;
  logic [7:0] link_byte = 8'h00, reg_rdata, crc, d, dir;
  logic [6:0] pin_in = 7'h00, pin_out, pin_oe, window_start;
  logic [3:0] window_byte_count;
  logic ready_n, gain_correction_sel, check_enable;
  logic rd_pend = 0; // A read was taken at the last edge
  reg_req_s reg_req;
  int fail_count = 0, checked = 0, cycles = 0;
  integer seed = 32'h1f40_60f9;
  logic [7:0] expq[$]; // Expected read data, oldest first
  always #12.5 core_clk = ~core_clk;
  afe_host_model host (.core_clk(core_clk), .req(reg_req));
  afe_spi_crc_gpio_control_regs dut (.core_clk(core_clk), .rst(rst), .reg_req(reg_req),
    .reg_rdata(reg_rdata), .sample_done(sample_done), .result_low_read(result_low_read),
    .link_byte(link_byte), .link_byte_valid(link_byte_valid), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe(pin_oe), .ready_n(ready_n), .window_start(window_start),
    .window_byte_count(window_byte_count), .gain_correction_sel(gain_correction_sel),
    .check_enable(check_enable));
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Note the expected value, then issue the read
  task automatic rd(input logic [6:0] a, input logic [7:0] e);
    expq.push_back(e);
    host.rd(a);
  endtask
  // Let pending reads drain and slow outputs settle, then sample 1 ns after the edge
  task automatic settle;
    for (int i = 0; i < 20 && expq.size() != 0; i++) @(posedge core_clk);
    repeat (3) @(posedge core_clk);
    #1;
  endtask
  // One-cycle pulses on the converter and link inputs
  task automatic ev(input logic s, input logic l, input logic v, input logic [7:0] b);
    @(posedge core_clk);
    sample_done <= s;
    result_low_read <= l;
    link_byte_valid <= v;
    link_byte <= b;
    @(posedge core_clk);
    sample_done <= 1'b0;
    result_low_read <= 1'b0;
    link_byte_valid <= 1'b0;
  endtask
  // Bench's own check reckoning: MSB first, polynomial 0x07
  function automatic logic [7:0] crc_step(input logic [7:0] c, input logic [7:0] b);
    logic [7:0] r;
    r = c ^ b;
    for (int i = 0; i < 8; i++) r = r[7] ? {r[6:0], 1'b0} ^ 8'h07 : {r[6:0], 1'b0};
    return r;
  endfunction
  // Three random link bytes, folded into the expected check
  task automatic burst;
    for (int i = 0; i < 3; i++) begin
      d = $random(seed);
      ev(1'b0, 1'b0, 1'b1, d);
      crc = crc_step(crc, d);
    end
  endtask
  // Enable, ready level and pin six state packed for one compare
  function automatic logic [7:0] pins();
    return {4'h0, check_enable, ready_n, pin_oe[6], pin_out[6]};
  endfunction
  // Monitor: read data is settled by the falling edge after the answer edge
  always @(posedge core_clk) rd_pend <= reg_req.rd;
  always @(negedge core_clk) begin
    if (rd_pend && expq.size() != 0) chk("reg_rdata", expq.pop_front(), reg_rdata);
  end
  // Hang guard; a full run needs well under a thousand cycles
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 4000) begin
      fail_count++;
      complete_run;
    end
  end
  initial begin
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    // Reset values, and an unmapped place
    rd(7'h09, 8'h1a);
    rd(7'h0a, 8'h02);
    rd(7'h0e, 8'h00);
    rd(7'h11, 8'h03);
    rd(7'h13, 8'h00);
    rd(7'h1d, 8'h00);
    rd(7'h20, 8'h00);
    settle;
    chk("count", 8'h03, 8'(window_byte_count));
    chk("pins", 8'h04, pins());
    chk("start", 8'h1a, 8'(window_start));
    host.wr(7'h09, 8'hff);
    rd(7'h09, 8'h7f);
    // Every count code, reserved bits random
    for (int k = 0; k < 8; k++) begin
      d = $random(seed);
      host.wr(7'h0a, {d[7:3], k[2:0]});
      rd(7'h0a, {5'h00, k[2:0]});
      settle;
      chk("count", 8'(k + 1), 8'(window_byte_count));
      chk("start", 8'h7f, 8'(window_start));
    end
    // Random directions, pin data and pin levels
    dir = $random(seed);
    d = $random(seed);
    pin_in <= 7'($random(seed));
    host.wr(7'h0e, dir);
    host.wr(7'h0f, d);
    rd(7'h0e, dir & 8'h7f);
    settle;
    chk("pin_oe", dir & 8'h7f, 8'(pin_oe));
    chk("pin_out", d & dir & 8'h7f, 8'(pin_out & pin_oe));
    rd(7'h0f, (d & dir & 8'h7f) | ({1'b0, pin_in} & ~dir & 8'h7f));
    // All pins inputs, so pin six can only drive because it carries ready
    host.wr(7'h0e, 8'h00);
    // Ready on pin six; release after the low byte clears the check
    host.wr(7'h11, 8'h80);
    host.wr(7'h13, 8'h10);
    rd(7'h11, 8'h83);
    crc = 8'h00;
    ev(1'b1, 1'b0, 1'b0, 8'h00);
    burst;
    rd(7'h1d, crc);
    settle;
    chk("pins", 8'h0a, pins());
    ev(1'b0, 1'b1, 1'b0, 8'h00);
    settle;
    chk("pins", 8'h0f, pins());
    rd(7'h1d, 8'h00);
    // Release waits for the check read; auto clear suppressed
    host.wr(7'h11, 8'ha8);
    host.wr(7'h13, 8'h1c);
    rd(7'h13, 8'h14);
    crc = 8'h00;
    ev(1'b1, 1'b0, 1'b0, 8'h00);
    burst;
    ev(1'b0, 1'b1, 1'b0, 8'h00);
    settle;
    chk("pins", 8'h0a, pins());
    chk("gain", 8'h01, 8'(gain_correction_sel));
    rd(7'h1d, crc);
    settle;
    chk("pins", 8'h0f, pins());
    rd(7'h1d, crc);
    // Any write to the check value clears it
    host.wr(7'h1d, 8'($random(seed)));
    rd(7'h1d, 8'h00);
    // Disabled check ignores link traffic
    host.wr(7'h13, 8'h00);
    burst;
    rd(7'h1d, 8'h00);
    settle;
    complete_run;
  end
endmodule
